// ==== src/mac_pkg.sv ====
// shared widths, constants and carrier types of the multiplier-accumulator
package mac_pkg;

  localparam int OPERAND_W = 12;
  localparam int WORD_W = 12;
  localparam int GUARD_W = 3;
  localparam int RESULT_W = 27;
  localparam int EXT_W = RESULT_W - OPERAND_W;
  localparam int OPERAND_SIGN_BIT = OPERAND_W - 1;
  localparam int GUARD_SIGN_BIT = GUARD_W - 1;

  // rounding adds one at bit 11 of the lower word
  localparam logic [RESULT_W-1:0] ROUND_ADD = 27'h0000800;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 27'h0000000;
  localparam logic [OPERAND_W-1:0] OPERAND_RESET = 12'h000;

  typedef struct packed {
    logic round_request;
    logic signed_mode;
    logic sum_with_previous;
    logic negate_previous;
  } mac_mode_type;

  localparam mac_mode_type MODE_RESET = 4'h0;

  typedef struct packed {
    logic guard_drive_disable;
    logic upper_drive_disable;
    logic lower_drive_disable;
  } mac_disable_type;

  typedef struct packed {
    logic guard_drive;
    logic upper_drive;
    logic lower_drive;
  } mac_drive_type;

  localparam mac_drive_type DRIVE_RESET = 3'h0;

  typedef struct packed {
    logic [GUARD_W-1:0] guard_result_bits;
    logic [WORD_W-1:0] upper_result_word;
    logic [WORD_W-1:0] lower_result_word;
  } mac_result_type;

  // every pin-side input, synchronised as one bundle
  typedef struct packed {
    logic [OPERAND_W-1:0] operand_a;
    logic [OPERAND_W-1:0] operand_b;
    logic operand_a_clock;
    logic operand_b_clock;
    logic result_clock;
    mac_mode_type mode;
    mac_disable_type drive_off;
    logic result_load_from_pins;
    mac_result_type result_in;
  } mac_pins_type;

endpackage : mac_pkg

// ==== src/mac_accum.sv ====
// 12 by 12 multiplier-accumulator with 27-bit sectioned result
//
// Behaviour
// - two 12-bit operands, bit 11 sign
// - operand registers load on own clock rise
// - result is product plus optional previous sum
// - result split guard 26:24, upper 23:12, lower
// - guard top bit carries sign when signed
// - three clocks; result loads on result_clock rise
// - modes captured on rise of operand clock OR
// - section floats while its disable is high
// - preload floats all three sections
// - preload plus disable loads pins into section
// - preload with disable low holds section
// - preload and disables not captured by operand clocks
// - round adds one at lower word bit 11
// - signed mode selects two's complement operands
// - sum mode adds previous result at next edge
// - no sum mode stores bare product, or product plus round when round set
// - negate with sum mode gives product minus previous result
`timescale 1ns/1ps
module mac_accum
  import mac_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [mac_pkg::OPERAND_W-1:0] operand_a,
  input wire logic [mac_pkg::OPERAND_W-1:0] operand_b,
  input wire logic operand_a_clock,
  input wire logic operand_b_clock,
  input wire logic result_clock,
  input wire mac_pkg::mac_mode_type mode_controls,
  input wire mac_pkg::mac_disable_type drive_disable,
  input wire logic result_load_from_pins,
  input wire mac_pkg::mac_result_type result_pins_in,
  output mac_pkg::mac_result_type result_pins_out,
  output mac_pkg::mac_drive_type result_pins_oe
);
  import mac_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  mac_pins_type pins_raw;
  mac_pins_type pins_meta_q;
  mac_pins_type pins_q;
  logic a_clock_last_q;
  logic b_clock_last_q;
  logic or_clock_last_q;
  logic result_clock_last_q;

  always_comb
  begin
    pins_raw.operand_a = operand_a;
    pins_raw.operand_b = operand_b;
    pins_raw.operand_a_clock = operand_a_clock;
    pins_raw.operand_b_clock = operand_b_clock;
    pins_raw.result_clock = result_clock;
    pins_raw.mode = mode_controls;
    pins_raw.drive_off = drive_disable;
    pins_raw.result_load_from_pins = result_load_from_pins;
    pins_raw.result_in = result_pins_in;
  end

  // data and clocks share one depth so a sampled edge sees aligned data
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pins_meta_q <= '0;
      pins_q <= '0;
    end
    else
    begin
      pins_meta_q <= pins_raw;
      pins_q <= pins_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // edge detection

  logic a_edge;
  logic b_edge;
  logic or_level;
  logic or_edge;
  logic result_edge;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      a_clock_last_q <= 1'b0;
      b_clock_last_q <= 1'b0;
      or_clock_last_q <= 1'b0;
      result_clock_last_q <= 1'b0;
    end
    else
    begin
      a_clock_last_q <= pins_q.operand_a_clock;
      b_clock_last_q <= pins_q.operand_b_clock;
      or_clock_last_q <= or_level;
      result_clock_last_q <= pins_q.result_clock;
    end
  end

  always_comb
  begin
    a_edge = pins_q.operand_a_clock & ~a_clock_last_q;
    b_edge = pins_q.operand_b_clock & ~b_clock_last_q;
    // low idle clocks give a single clean rise of the OR
    or_level = pins_q.operand_a_clock | pins_q.operand_b_clock;
    or_edge = or_level & ~or_clock_last_q;
    result_edge = pins_q.result_clock & ~result_clock_last_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // operand and mode registers

  logic [OPERAND_W-1:0] operand_a_q;
  logic [OPERAND_W-1:0] operand_b_q;
  mac_mode_type mode_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      operand_a_q <= OPERAND_RESET;
    else if (a_edge)
      operand_a_q <= pins_q.operand_a;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      operand_b_q <= OPERAND_RESET;
    else if (b_edge)
      operand_b_q <= pins_q.operand_b;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      mode_q <= MODE_RESET;
    else if (or_edge)
      mode_q <= pins_q.mode;
  end

  //////////////////////////////////////////////////////////////////////////
  // arithmetic

  function automatic logic [RESULT_W-1:0] mac_extend(
    input logic [OPERAND_W-1:0] value,
    input logic as_signed
  );
    logic fill;
    fill = as_signed & value[OPERAND_SIGN_BIT];
    return {{EXT_W{fill}}, value};
  endfunction : mac_extend

  logic [RESULT_W-1:0] ext_a;
  logic [RESULT_W-1:0] ext_b;
  logic [RESULT_W-1:0] product;
  logic [RESULT_W-1:0] previous;
  logic [RESULT_W-1:0] acc_term;
  logic [RESULT_W-1:0] round_term;
  logic [RESULT_W-1:0] calc_result;

  mac_result_type result_q;

  always_comb
  begin
    ext_a = mac_extend(operand_a_q, mode_q.signed_mode);
    ext_b = mac_extend(operand_b_q, mode_q.signed_mode);
    // low 27 bits of the extended product wrap modulo two to the 27
    product = ext_a * ext_b;
    previous = result_q;
    if (!mode_q.sum_with_previous)
      acc_term = RESULT_RESET;
    else if (mode_q.negate_previous)
      acc_term = RESULT_RESET - previous;
    else
      acc_term = previous;
    round_term = mode_q.round_request ? ROUND_ADD : RESULT_RESET;
    calc_result = product + acc_term + round_term;
  end

  //////////////////////////////////////////////////////////////////////////
  // result register and preload

  function automatic logic [RESULT_W-1:0] mac_section_mask(
    input mac_disable_type off
  );
    return {{GUARD_W{off.guard_drive_disable}},
            {WORD_W{off.upper_drive_disable}},
            {WORD_W{off.lower_drive_disable}}};
  endfunction : mac_section_mask

  logic [RESULT_W-1:0] load_mask;
  logic [RESULT_W-1:0] preload_result;

  always_comb
  begin
    // preload and disables are live levels, never operand-clocked
    load_mask = mac_section_mask(pins_q.drive_off);
    preload_result = (load_mask & pins_q.result_in)
                   | (~load_mask & previous);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      result_q <= RESULT_RESET;
    else if (result_edge)
    begin
      if (pins_q.result_load_from_pins)
        result_q <= preload_result;
      else
        result_q <= calc_result;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output drivers

  mac_drive_type oe_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      oe_q <= DRIVE_RESET;
    else
    begin
      oe_q.guard_drive <= ~(pins_q.drive_off.guard_drive_disable
                          | pins_q.result_load_from_pins);
      oe_q.upper_drive <= ~(pins_q.drive_off.upper_drive_disable
                          | pins_q.result_load_from_pins);
      oe_q.lower_drive <= ~(pins_q.drive_off.lower_drive_disable
                          | pins_q.result_load_from_pins);
    end
  end

  assign result_pins_out = result_q;
  assign result_pins_oe = oe_q;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic product_negative;

  always_comb
  begin
    product_negative = (operand_a_q[OPERAND_SIGN_BIT]
                       ^ operand_b_q[OPERAND_SIGN_BIT])
                     & (|operand_a_q) & (|operand_b_q);
  end

  sequence s_calc_edge;
    result_edge && !pins_q.result_load_from_pins;
  endsequence

  sequence s_preload_edge;
    result_edge && pins_q.result_load_from_pins;
  endsequence

  property p_operand_a_capture;
    a_edge |=> operand_a_q == $past(pins_q.operand_a);
  endproperty
  a_operand_a_capture: assert property (p_operand_a_capture)
    else $error("operand a not captured on its clock rise");

  property p_operand_b_hold;
    !b_edge |=> $stable(operand_b_q);
  endproperty
  a_operand_b_hold: assert property (p_operand_b_hold)
    else $error("operand b changed without a clock rise");

  property p_mode_capture;
    (pins_q.operand_a_clock && !a_clock_last_q && !b_clock_last_q)
      |=> mode_q == $past(pins_q.mode);
  endproperty
  a_mode_capture: assert property (p_mode_capture)
    else $error("mode controls not captured on operand clock rise");

  property p_result_idle;
    !result_edge |=> $stable(result_q);
  endproperty
  a_result_idle: assert property (p_result_idle)
    else $error("result changed without a result clock rise");

  property p_plain_product;
    s_calc_edge ##0 (!mode_q.sum_with_previous && !mode_q.round_request)
      |=> result_q == $past(product);
  endproperty
  a_plain_product: assert property (p_plain_product)
    else $error("bare product not stored");

  property p_accumulate;
    s_calc_edge ##0 (mode_q.sum_with_previous && !mode_q.negate_previous
      && !mode_q.round_request)
      |=> result_q == RESULT_W'($past(product) + $past(result_q));
  endproperty
  a_accumulate: assert property (p_accumulate)
    else $error("accumulated sum wrong");

  property p_subtract;
    s_calc_edge ##0 (mode_q.sum_with_previous && mode_q.negate_previous
      && !mode_q.round_request)
      |=> result_q == RESULT_W'($past(product) - $past(result_q));
  endproperty
  a_subtract: assert property (p_subtract)
    else $error("difference is not product minus previous");

  property p_round;
    s_calc_edge ##0 (!mode_q.sum_with_previous && mode_q.round_request)
      |=> result_q == RESULT_W'($past(product) + ROUND_ADD);
  endproperty
  a_round: assert property (p_round)
    else $error("rounding bit not added");

  property p_sign_in_guard;
    s_calc_edge ##0 (mode_q.signed_mode && !mode_q.sum_with_previous
      && !mode_q.round_request)
      |=> result_q.guard_result_bits[GUARD_SIGN_BIT]
          == $past(product_negative);
  endproperty
  a_sign_in_guard: assert property (p_sign_in_guard)
    else $error("guard top bit does not carry product sign");

  property p_preload_upper;
    s_preload_edge ##0 pins_q.drive_off.upper_drive_disable
      |=> result_q.upper_result_word
          == $past(pins_q.result_in.upper_result_word);
  endproperty
  a_preload_upper: assert property (p_preload_upper)
    else $error("upper word not preloaded from pins");

  property p_preload_hold_lower;
    s_preload_edge ##0 !pins_q.drive_off.lower_drive_disable
      |=> $stable(result_q.lower_result_word);
  endproperty
  a_preload_hold_lower: assert property (p_preload_hold_lower)
    else $error("lower word changed during preload");

  property p_preload_floats;
    pins_q.result_load_from_pins |=> oe_q == DRIVE_RESET;
  endproperty
  a_preload_floats: assert property (p_preload_floats)
    else $error("a section drives during preload");

  property p_guard_drive;
    (!pins_q.result_load_from_pins
      && !pins_q.drive_off.guard_drive_disable) [*2]
      |-> oe_q.guard_drive;
  endproperty
  a_guard_drive: assert property (p_guard_drive)
    else $error("guard section not driven while enabled");

endmodule : mac_accum

// ==== dv/mac_host.sv ====
// host-side pin model that resolves the shared result wire
`timescale 1ns/1ps
module mac_host
  import mac_pkg::*;
(
  input wire logic sys_clk,
  input wire mac_pkg::mac_result_type pins_out,
  input wire mac_pkg::mac_drive_type pins_oe,
  input wire mac_pkg::mac_drive_type host_oe,
  input wire mac_pkg::mac_result_type host_value,
  output mac_pkg::mac_result_type pins_in
);
  logic [26:0] dev_m;
  logic [26:0] host_m;
  logic [26:0] float_q = 27'h2aaaaaa;
  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    dev_m = {{3{pins_oe[2]}}, {12{pins_oe[1]}}, {12{pins_oe[0]}}};
    host_m = {{3{host_oe[2]}}, {12{host_oe[1]}}, {12{host_oe[0]}}};
  end
  // undriven sections show a pattern that changes every cycle
  always_ff @(posedge sys_clk)
  begin
    float_q <= ~float_q;
  end
  // host drives preload data onto floated sections
  assign pins_in = (pins_out & dev_m) | (host_value & host_m & ~dev_m)
    | (float_q & ~dev_m & ~host_m);
endmodule : mac_host

// ==== dv/mac_accum_tb.sv ====
// self-checking bench for the multiplier-accumulator
`timescale 1ns/1ps
module mac_accum_tb;
  import mac_pkg::*;
  logic sys_clk;
  logic rst;
  logic [11:0] operand_a;
  logic [11:0] operand_b;
  logic operand_a_clock;
  logic operand_b_clock;
  logic result_clock;
  mac_mode_type mode_controls;
  mac_disable_type drive_disable;
  logic result_load_from_pins;
  mac_result_type result_pins_in;
  mac_result_type result_pins_out;
  mac_drive_type result_pins_oe;
  mac_drive_type host_oe;
  mac_result_type host_value;
  int mismatches;
  int checks;
  //////////////////////////////////////////////////////////////////////////
  mac_accum u_mac_accum (
    .sys_clk(sys_clk), .rst(rst), .operand_a(operand_a),
    .operand_b(operand_b), .operand_a_clock(operand_a_clock),
    .operand_b_clock(operand_b_clock), .result_clock(result_clock),
    .mode_controls(mode_controls), .drive_disable(drive_disable),
    .result_load_from_pins(result_load_from_pins),
    .result_pins_in(result_pins_in), .result_pins_out(result_pins_out),
    .result_pins_oe(result_pins_oe)
  );
  mac_host u_mac_host (
    .sys_clk(sys_clk), .pins_out(result_pins_out), .pins_oe(result_pins_oe),
    .host_oe(host_oe), .host_value(host_value), .pins_in(result_pins_in)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  task check(input logic [26:0] seen, input logic [26:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // operand clocks idle low and pulse high
  task pulse_ops(input logic pa, input logic pb);
    operand_a_clock = pa;
    operand_b_clock = pb;
    step(3);
    operand_a_clock = 1'b0;
    operand_b_clock = 1'b0;
    step(3);
  endtask : pulse_ops
  task pulse_res;
    result_clock = 1'b1;
    step(3);
    result_clock = 1'b0;
    step(4);
  endtask : pulse_res
  // modes are scrambled after capture; the result must not see it
  task run(input logic [11:0] a, input logic [11:0] b,
    input logic [3:0] m, input logic [26:0] exp);
    operand_a = a;
    operand_b = b;
    mode_controls = mac_mode_type'(m);
    pulse_ops(1'b1, 1'b1);
    mode_controls = mac_mode_type'(~m);
    pulse_res();
    check(result_pins_out, exp);
  endtask : run
  //////////////////////////////////////////////////////////////////////////
  task test_unsigned;
    run(12'hfff, 12'hfff, 4'h0, 27'h0ffe001);
    run(12'h123, 12'h456, 4'h0, 27'h004edc2);
    check(result_pins_out.lower_result_word, 12'hdc2);
    check(result_pins_out.upper_result_word, 12'h04e);
  endtask : test_unsigned
  task test_signed;
    run(12'hfff, 12'h002, 4'h4, 27'h7fffffe);
    check(result_pins_out.guard_result_bits[2], 1'b1);
  endtask : test_signed
  task test_accum;
    run(12'h003, 12'h004, 4'h4, 27'h000000c);
    run(12'h002, 12'h005, 4'h6, 27'h0000016);
    run(12'h001, 12'h005, 4'h7, 27'h7ffffef);
    run(12'h002, 12'h003, 4'h5, 27'h0000006);
    run(12'h001, 12'h001, 4'h8, 27'h0000801);
  endtask : test_accum
  task test_hold;
    run(12'h004, 12'h003, 4'h0, 27'h000000c);
    mode_controls = mac_mode_type'(4'h0);
    operand_a = 12'h7ff;
    operand_b = 12'h002;
    pulse_ops(1'b0, 1'b1);
    pulse_res();
    check(result_pins_out, 27'h0000008);
    operand_b = 12'h001;
    pulse_ops(1'b1, 1'b0);
    pulse_res();
    check(result_pins_out, 27'h0000ffe);
  endtask : test_hold
  task test_drive;
    logic [2:0] d;
    for (int i = 0; i < 8; i++)
    begin
      d = 3'(i);
      drive_disable = mac_disable_type'(d);
      result_load_from_pins = 1'b0;
      step(4);
      check(27'(result_pins_oe), 27'(d ^ 3'h7));
      result_load_from_pins = 1'b1;
      step(4);
      check(27'(result_pins_oe), 27'h0);
    end
    result_load_from_pins = 1'b0;
    drive_disable = mac_disable_type'(3'h0);
    step(4);
  endtask : test_drive
  task test_preload;
    run(12'h003, 12'h004, 4'h0, 27'h000000c);
    result_load_from_pins = 1'b1;
    drive_disable = mac_disable_type'(3'h2);
    host_oe = mac_drive_type'(3'h2);
    host_value = mac_result_type'(27'h2abc123);
    step(4);
    pulse_res();
    check(result_pins_out, 27'h0abc00c);
    drive_disable = mac_disable_type'(3'h7);
    host_oe = mac_drive_type'(3'h7);
    host_value = mac_result_type'(27'h7ffffff);
    step(4);
    pulse_res();
    check(result_pins_out, 27'h7ffffff);
    result_load_from_pins = 1'b0;
    drive_disable = mac_disable_type'(3'h0);
    host_oe = mac_drive_type'(3'h0);
    step(4);
    run(12'h001, 12'h001, 4'h2, 27'h0000000);
  endtask : test_preload
  task results;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    mismatches = 0;
    checks = 0;
    rst = 1'b1;
    operand_a = 12'h000;
    operand_b = 12'h000;
    operand_a_clock = 1'b0;
    operand_b_clock = 1'b0;
    result_clock = 1'b0;
    mode_controls = mac_mode_type'(4'h0);
    drive_disable = mac_disable_type'(3'h0);
    result_load_from_pins = 1'b0;
    host_oe = mac_drive_type'(3'h0);
    host_value = mac_result_type'(27'h0);
    step(5);
    check(result_pins_out, 27'h0);
    rst = 1'b0;
    step(3);
    test_unsigned();
    test_signed();
    test_accum();
    test_hold();
    test_drive();
    test_preload();
    results();
  end
endmodule : mac_accum_tb
